//--- hw/cmpc_defines.svh
// Offsets, field positions and reset values for the comparator control block
`ifndef CMPC_DEFINES_SVH
`define CMPC_DEFINES_SVH

`define CMPC_OFS_CTRL_ONE   12'h000
`define CMPC_OFS_CTRL_TWO   12'h004
`define CMPC_CTRL_RESET     32'h0000_0000

`define CMPC_BIT_LOCK       31
`define CMPC_BIT_VALUE      30
`define CMPC_POS_MEXT       25
`define CMPC_BIT_SCALE      23
`define CMPC_BIT_BRIDGE     22
`define CMPC_POS_BLANK      18
`define CMPC_POS_HYST       16
`define CMPC_BIT_POLARITY   15
`define CMPC_BIT_WINDOW     9
`define CMPC_POS_PLUS       7
`define CMPC_POS_MINUS      4
`define CMPC_POS_POWER      2
`define CMPC_BIT_ENABLE     0

// Masks; the write masks give the writable bits; bit 9 only exists in the second register
`define CMPC_MASK_ONE       32'hFEDF_8000
`define CMPC_WMASK_ONE      32'h86DF_81FD
`define CMPC_WMASK_TWO      32'h86DF_83FD

`define CMPC_RESP_OKAY      2'h0
`define CMPC_RESP_SLVERR    2'h2

`endif

//--- hw/cmpc_pkg.sv
// Types shared by the comparator control block
package cmpc_pkg;

  typedef enum logic [1:0] {
    CMPC_PWR_HIGH,
    CMPC_PWR_MEDIUM,
    CMPC_PWR_ULTRA_LOW
  } cmpc_power_e;

  // Decoded analog steering for one comparator core
  typedef struct packed {
    logic        enable;
    logic [2:0]  plus_onehot;
    logic [10:0] minus_onehot;
    logic [1:0]  hysteresis;
    cmpc_power_e power;
    logic        scaler_enable;
    logic        bridge_enable;
  } cmpc_analog_s;

  // Destinations of one comparator output
  typedef struct packed {
    logic pin;
    logic break_input;
    logic break_input_second;
    logic reference_clear;
    logic capture;
    logic event_line;
  } cmpc_route_s;

endpackage

//--- hw/cmpc_top.sv
// Comparator control: registers, input steering, blanking and output routing
//
// Functional notes
// - Plus selector 00, 01, 10 picks first, second, third pin; 11 reserved.
// - Minus codes 000-011 reference fractions, 100/101 converter, 110 pin.
// - Minus code 111 uses extended selector; otherwise extended is ignored.
// - Setting lock makes the whole control register read-only, lock included.
// - Only reset clears the lock; software cannot remove it.
// - Output is comparator after polarity AND NOT selected blanking signal.
// - Blanking source is a timer compare chosen by a register field.
// - Window join ties both plus inputs to the first comparator's pin.
// - Power select 00 high, 01/10 medium, 11 ultra-low power.
// - Polarity and pin output path are combinational, independent of clock.
// - Output drives pin and timer inputs at the same time.
// - Output offered to break, reference-clear and capture inputs.
// - Each comparator output drives its own event controller line.
// - Registers run on the bus clock, sharing reset and enable.
// - Hysteresis is programmable, including a no-hysteresis setting.
// - Polarity bit set inverts the output, clear passes it.
// - Read-only status bit shows the output after polarity.
// - Blanking code 000 off, 001/010 timer compares, others reserved.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "cmpc_defines.svh"

module cmpc_top (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      clk_en,
  input  wire logic [11:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [11:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [1:0]                comparator_raw,
  input  wire logic [1:0]                blank_compare_a,
  input  wire logic [1:0]                blank_compare_b,
  output cmpc_pkg::cmpc_analog_s [1:0]   analog_ctrl,
  output cmpc_pkg::cmpc_route_s [1:0]    comparator_route
);
  import cmpc_pkg::*;

  // Control word layout, the same in both registers:
  //   31     lock, set once by software, cleared only by reset
  //   30     output status after polarity, read-only
  //   26:25  extended minus pin, used only under minus code 111
  //   23     reference scaler enable
  //   22     scaler bridge enable
  //   20:18  blanking source
  //   17:16  hysteresis, 00 turns it off
  //   15     polarity
  //   9      window join, second register only
  //   8:7    plus input
  //   6:4    minus input
  //   3:2    power and speed
  //   0      core enable
  // Every other bit reads as zero and ignores writes.
  // Both words reset to all zeros, so the cores start switched off.

  typedef struct packed {
    logic [1:0][31:0] ctrl;
    logic             aw_held;
    logic [11:0]      aw_addr;
    logic             w_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    cmpc_analog_s [1:0] analog;
  } cmpc_state_s;

  cmpc_state_s state_reg;
  cmpc_state_s state_next;
  logic [1:0]  status_value;
  logic [1:0]  final_out;

  // Returns register index 0/1 for a mapped address, 2 for unmapped
  function automatic logic [1:0] cmpc_decode(input logic [11:0] addr);
    case (addr)
      `CMPC_OFS_CTRL_ONE: cmpc_decode = 2'd0;
      `CMPC_OFS_CTRL_TWO: cmpc_decode = 2'd1;
      default:            cmpc_decode = 2'd2;
    endcase
  endfunction

  function automatic cmpc_power_e cmpc_power(input logic [1:0] code);
    case (code)
      2'b00:   cmpc_power = CMPC_PWR_HIGH;
      2'b11:   cmpc_power = CMPC_PWR_ULTRA_LOW;
      default: cmpc_power = CMPC_PWR_MEDIUM;
    endcase
  endfunction

  // Plus steering; reserved code 11 leaves every plus switch open
  function automatic logic [2:0] cmpc_plus(input logic [1:0] code);
    case (code)
      2'b00:   cmpc_plus = 3'b001;
      2'b01:   cmpc_plus = 3'b010;
      2'b10:   cmpc_plus = 3'b100;
      default: cmpc_plus = 3'b000;
    endcase
  endfunction

  // One-hot for the four extended minus pins, bits 7..10
  function automatic logic [10:0] cmpc_ext_pin(input logic [1:0] code);
    case (code)
      2'b00:   cmpc_ext_pin = 11'h080;
      2'b01:   cmpc_ext_pin = 11'h100;
      2'b10:   cmpc_ext_pin = 11'h200;
      default: cmpc_ext_pin = 11'h400;
    endcase
  endfunction

  // Timer compare used as blanking window; reserved codes never blank
  function automatic logic cmpc_blank(input logic [2:0] code,
                                      input logic       cmp_a,
                                      input logic       cmp_b);
    case (code)
      3'b001:  cmpc_blank = cmp_a;
      3'b010:  cmpc_blank = cmp_b;
      default: cmpc_blank = 1'b0;
    endcase
  endfunction

  // Byte lanes and the writable mask together decide which bits move
  function automatic logic [31:0] cmpc_merge(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0]  strb,
                                             input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = '0;
    for (int b = 0; b < 4; b++) begin
      lanes[b*8 +: 8] = {8{strb[b]}};
    end
    return (old_word & ~(lanes & wmask)) | (new_word & lanes & wmask);
  endfunction

  // Read view: stored word with the live status in the read-only bit
  function automatic logic [31:0] cmpc_read_word(input logic [31:0] word,
                                                 input logic        value);
    logic [31:0] r;
    r                  = word;
    r[`CMPC_BIT_VALUE] = value;
    return r;
  endfunction

  // Analog steering decode from one control word
  function automatic cmpc_analog_s cmpc_steer(input logic [31:0] c,
                                              input logic        join_plus);
    cmpc_analog_s a;
    logic [1:0]   plus_code;
    logic [2:0]   minus_code;
    logic [1:0]   ext_code;
    a          = '0;
    plus_code  = c[`CMPC_POS_PLUS +: 2];
    minus_code = c[`CMPC_POS_MINUS +: 3];
    ext_code   = c[`CMPC_POS_MEXT +: 2];
    a.enable   = c[`CMPC_BIT_ENABLE];
    a.plus_onehot = cmpc_plus(plus_code);
    // Second core borrows the first core's plus pin, freeing its own
    if (join_plus) begin
      a.plus_onehot = 3'b000;
    end
    // Bits 0..6 fixed sources, 7..10 extended pins
    // The extended code is read only under minus code 111, so a stale
    // extended field never leaks onto the other sources
    case (minus_code)
      3'b000:  a.minus_onehot = 11'h001;   // quarter reference
      3'b001:  a.minus_onehot = 11'h002;   // half reference
      3'b010:  a.minus_onehot = 11'h004;   // three-quarter reference
      3'b011:  a.minus_onehot = 11'h008;   // full reference
      3'b100:  a.minus_onehot = 11'h010;   // converter channel one
      3'b101:  a.minus_onehot = 11'h020;   // converter channel two
      3'b110:  a.minus_onehot = 11'h040;   // dedicated pin
      default: a.minus_onehot = cmpc_ext_pin(ext_code);
    endcase
    a.hysteresis    = c[`CMPC_POS_HYST +: 2];
    a.power         = cmpc_power(c[`CMPC_POS_POWER +: 2]);
    a.scaler_enable = c[`CMPC_BIT_SCALE];
    a.bridge_enable = c[`CMPC_BIT_BRIDGE];
    return a;
  endfunction

  // Output path has no flop so it keeps working with the clock stopped
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_out
      logic [2:0] blank_code;
      logic       blank_sel;
      assign blank_code = state_reg.ctrl[gi][`CMPC_POS_BLANK +: 3];
      assign blank_sel  = cmpc_blank(blank_code, blank_compare_a[gi],
                                     blank_compare_b[gi]);
      // Status and route bypass every flop: a stopped bus clock must
      // not freeze a protection trip that is already under way
      assign status_value[gi] = comparator_raw[gi]
                                ^ state_reg.ctrl[gi][`CMPC_BIT_POLARITY];
      assign final_out[gi] = status_value[gi] & ~blank_sel;
      // Every destination sees the same level; none shuts out another
      assign comparator_route[gi] = '{
        pin:                final_out[gi],
        break_input:        final_out[gi],
        break_input_second: final_out[gi],
        reference_clear:    final_out[gi],
        capture:            final_out[gi],
        event_line:         final_out[gi]
      };
    end
  endgenerate

  // Analog controls come straight from registered copies
  assign analog_ctrl   = state_reg.analog;
  assign s_axi_awready = ~state_reg.aw_held;
  assign s_axi_wready  = ~state_reg.w_held;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = ~state_reg.rvalid;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;

  always_comb begin
    logic [1:0]  widx;
    logic [1:0]  ridx;
    logic [31:0] wmask;
    logic [31:0] rword;
    widx       = 2'd0;
    ridx       = 2'd0;
    wmask      = '0;
    rword      = '0;
    state_next = state_reg;

    // Write address and write data are captured independently, in
    // either order. The commit waits until both are held and any
    // earlier response has been taken, so one write is in flight.
    // awready and wready stay low from capture to commit.
    if (s_axi_awvalid && !state_reg.aw_held) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_held) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end

    // Both halves held and no response pending: commit
    if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
      widx  = cmpc_decode(state_reg.aw_addr);
      wmask = (widx == 2'd1) ? `CMPC_WMASK_TWO : `CMPC_WMASK_ONE;
      if (widx != 2'd2) begin
        // Locked word keeps every bit; only reset reopens it
        if (!state_reg.ctrl[widx[0]][`CMPC_BIT_LOCK]) begin
          state_next.ctrl[widx[0]] = cmpc_merge(state_reg.ctrl[widx[0]],
                                                state_reg.w_data,
                                                state_reg.w_strb,
                                                wmask);
        end
        state_next.bresp = `CMPC_RESP_OKAY;
      end else begin
        state_next.bresp = `CMPC_RESP_SLVERR;
      end
      state_next.bvalid  = 1'b1;
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // A read is answered one edge after it is taken. The status bit is
    // a snapshot of that edge; it may already differ when rready comes.
    if (s_axi_arvalid && !state_reg.rvalid) begin
      ridx = cmpc_decode(s_axi_araddr);
      if (ridx != 2'd2) begin
        rword = cmpc_read_word(state_reg.ctrl[ridx[0]],
                               status_value[ridx[0]]);
        state_next.rresp = `CMPC_RESP_OKAY;
      end else begin
        state_next.rresp = `CMPC_RESP_SLVERR;
      end
      state_next.rdata  = rword;
      state_next.rvalid = 1'b1;
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end

    // Decoded from the next word, so the steering flops change on the
    // same edge as the control word and never lag it by a cycle
    state_next.analog[0] = cmpc_steer(state_next.ctrl[0], 1'b0);
    state_next.analog[1] = cmpc_steer(state_next.ctrl[1],
                             state_next.ctrl[1][`CMPC_BIT_WINDOW]);
  end

  // Bus-clock registers, shared reset and enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Field by field, so every flop gets exactly one reset value
      state_reg.ctrl[0] <= `CMPC_CTRL_RESET;
      state_reg.ctrl[1] <= `CMPC_CTRL_RESET;
      state_reg.aw_held <= 1'b0;
      state_reg.aw_addr <= 12'h000;
      state_reg.w_held  <= 1'b0;
      state_reg.w_data  <= 32'h0000_0000;
      state_reg.w_strb  <= 4'h0;
      state_reg.bvalid  <= 1'b0;
      state_reg.bresp   <= `CMPC_RESP_OKAY;
      state_reg.rvalid  <= 1'b0;
      state_reg.rdata   <= 32'h0000_0000;
      state_reg.rresp   <= `CMPC_RESP_OKAY;
      state_reg.analog  <= {2{cmpc_steer(`CMPC_CTRL_RESET, 1'b0)}};
    end else if (clk_en) begin
      // Enable low holds the bus and the steering; reset still acts
      state_reg <= state_next;
    end
  end

endmodule

//--- tb/cmpc_asserts.sv
// Port-level checker for the comparator control block
`timescale 1ns/100ps
module cmpc_asserts (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [1:0]              s_axi_rresp,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire cmpc_pkg::cmpc_analog_s [1:0] analog_ctrl,
  input wire cmpc_pkg::cmpc_route_s [1:0]  comparator_route
);
  import cmpc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_route_fanout: assert property (
    comparator_route[0] inside {6'h00, 6'h3F}
    && comparator_route[1] inside {6'h00, 6'h3F})
    else $error("route fields disagree");
  a_plus_onehot: assert property (
    $onehot0(analog_ctrl[0].plus_onehot)
    && $onehot0(analog_ctrl[1].plus_onehot))
    else $error("plus steering not one-hot");
  a_minus_onehot: assert property (
    $onehot(analog_ctrl[0].minus_onehot)
    && $onehot(analog_ctrl[1].minus_onehot))
    else $error("minus steering not one-hot");
  a_power_legal: assert property (
    analog_ctrl[0].power != 2'h3 && analog_ctrl[1].power != 2'h3)
    else $error("power code out of range");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rresp_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read response dropped");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_aw_busy: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*1] ##0 1)
    else $error("address taken twice");

  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_join: cover property (analog_ctrl[1].plus_onehot == 3'h0);
  c_out_high: cover property (comparator_route[0].pin);
endmodule

bind cmpc_top cmpc_asserts cmpc_asserts_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .analog_ctrl,
  .comparator_route);

//--- tb/cmpc_core_model.sv
// Behavioural analog cores: output high when enabled and input above
`timescale 1ns/100ps
module cmpc_core_model (
  input  wire cmpc_pkg::cmpc_analog_s [1:0] analog_ctrl,
  input  wire logic [1:0]                   above,
  output logic [1:0]                        comparator_raw
);
  import cmpc_pkg::*;
  // A core switched off drives low rather than a stale decision
  assign comparator_raw = {analog_ctrl[1].enable & above[1],
                           analog_ctrl[0].enable & above[0]};
endmodule

//--- tb/cmpc_top_tb.sv
// Self-checking bench for the comparator control block
`timescale 1ns/100ps
module cmpc_top_tb;
  import cmpc_pkg::*;
  logic              aclk = 0, aresetn = 0;
  logic [11:0]       s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata, rv;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic              s_axi_arvalid = 0, s_axi_rready = 0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, comparator_raw, above = '0;
  logic [1:0]        blank_compare_a = '0, blank_compare_b = '0;
  cmpc_analog_s [1:0] analog_ctrl;
  cmpc_route_s [1:0] comparator_route;
  int                fails = 0, n_compared = 0;

  initial begin
    forever #10 aclk = ~aclk;
  end

  cmpc_top cmpc_top_i (.aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .comparator_raw, .blank_compare_a,
    .blank_compare_b, .analog_ctrl, .comparator_route);
  cmpc_core_model cmpc_core_model_i (.analog_ctrl, .above, .comparator_raw);

  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic stuck;
    fails++;
    $display("Error handshake expected answer seen none");
    report_and_stop();
  endtask

  // Handshakes are judged at mid-cycle, where registered outputs are settled
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, b;
    logic [1:0] r;
    b = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int n = 0; n < 40 && !b; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (b) s_axi_bready <= 0;
    end
    if (!b) stuck();
    chk("bresp", er, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er);
    logic t, v;
    logic [1:0] r;
    v = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int n = 0; n < 40 && !v; n++) begin
      @(negedge aclk);
      t = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      r = s_axi_rresp;
      rv = s_axi_rdata;
      @(posedge aclk);
      if (t) s_axi_arvalid <= 0;
      if (v) s_axi_rready <= 0;
    end
    if (!v) stuck();
    chk("rresp", er, r);
  endtask

  task automatic t_sel;
    logic [31:0] d;
    for (int k = 0; k < 11; k++) begin
      d = (32'(k < 7 ? 3 : k - 7) << 25) | (32'(k % 4) << 16)
        | (32'(k % 3) << 7) | (32'(k < 7 ? k : 7) << 4) | (32'(k % 4) << 2);
      wr(12'h000, d, 2'h0);
      rd(12'h000, 2'h0);
      chk("readback", d, rv);
      @(negedge aclk);
      chk("plus", 32'h1 << (k % 3), analog_ctrl[0].plus_onehot);
      chk("minus", 32'h1 << k, analog_ctrl[0].minus_onehot);
      chk("hyst", k % 4, analog_ctrl[0].hysteresis);
      chk("power", k % 4 == 0 ? CMPC_PWR_HIGH : k % 4 == 3 ? CMPC_PWR_ULTRA_LOW
          : CMPC_PWR_MEDIUM, analog_ctrl[0].power);
    end
    $display("selector test done");
  endtask

  task automatic t_out;
    logic ex;
    for (int k = 0; k < 32; k++) begin
      wr(12'h000, 32'h1 | (32'(k % 2) << 15) | (32'(k / 8) << 18), 2'h0);
      @(posedge aclk);
      above <= {1'b0, k[1]};
      blank_compare_a <= {1'b0, k[2]};
      blank_compare_b <= {1'b0, ~k[2]};
      ex = (k[1] ^ k[0]) & ~(k / 8 == 1 ? k[2] : k / 8 == 2 ? ~k[2] : 1'b0);
      @(negedge aclk);
      chk("route", {26'h0, {6{ex}}}, comparator_route[0]);
      chk("route two", 32'h0, comparator_route[1]);
      rd(12'h000, 2'h0);
      chk("value", k[1] ^ k[0], rv[30]);
    end
    $display("output test done");
  endtask

  task automatic t_win;
    wr(12'h004, 32'h0000_0200, 2'h0);
    @(negedge aclk);
    chk("join plus", 32'h0, analog_ctrl[1].plus_onehot);
    wr(12'h000, 32'h0000_0200, 2'h0);
    rd(12'h000, 2'h0);
    chk("join in one", 32'h0, rv);
    $display("window test done");
  endtask

  task automatic t_lock;
    wr(12'h004, 32'h8000_0011, 2'h0);
    wr(12'h004, 32'h0000_0000, 2'h0);
    rd(12'h004, 2'h0);
    chk("locked", 32'h8000_0011, rv);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(12'h004, 2'h0);
    chk("after reset", 32'h0, rv);
    chk("plus reset", 32'h1, analog_ctrl[0].plus_onehot);
    wr(12'h008, 32'h1, 2'h2);
    rd(12'h008, 2'h2);
    $display("lock test done");
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_sel();
    t_out();
    t_win();
    t_lock();
    report_and_stop();
  end
endmodule
